/* design/eth_status_map.vh */
// register map, field positions and reset values of the ethernet status block
`ifndef ETH_STATUS_MAP_VH
`define ETH_STATUS_MAP_VH

// register base byte addresses (word aligned)
`define IRQ_REQ_BASE      6'h00
`define RXOK_STATS_BASE   6'h10
`define IRQ_STAT_BASE     6'h20
`define IRQ_MASK_BASE     6'h24
`define RX_BUFFER_COUNT_BASE       6'h28

// alias word offsets added to a register base
`define ALIAS_DIRECT      2'h0
`define ALIAS_CLEAR       2'h1
`define ALIAS_SET         2'h2
`define ALIAS_INVERT      2'h3

// flag positions in the interrupt request register
`define FLAG_OVFLW        0
`define FLAG_BUFNA        1
`define FLAG_ABORT        2
`define FLAG_DONE         3
`define FLAG_UNUSED       4
`define FLAG_ACT          5
`define FLAG_PEND         6
`define FLAG_W            7

// writable (software changeable) flags: all but pending and the unused bit
`define FLAG_SW_MASK      7'h2f

// counter widths, steps and reset values
`define RXOK_W            16
`define RXOK_RESET        16'h0000
`define RX_BUFFER_COUNT_W          8
`define RX_BUFFER_COUNT_RESET      8'h00
`define RXOK_STEP         16'h0001
`define BUF_STEP          8'h01
`define FLAGS_RESET       7'h00
`define EV_RESET          2'h0
`define EV_BIT_RESET      1'b0

// block event status bits
`define EV_W              2
`define EV_PEND           0
`define EV_RXOK_WRAP      1

`define ZERO32            32'h00000000
`endif

/* design/eth_irq_status.v */
// ethernet interrupt request flags, frames-received-ok counter, wishbone slave
`timescale 1ns/1ps
`include "eth_status_map.vh"

module eth_irq_status (
	// clock and reset
	input  wire        clk_i,
	input  wire        rst_i,
	// wishbone classic slave
	input  wire        cyc_i,
	input  wire        stb_i,
	input  wire        we_i,
	input  wire [5:0]  adr_i,
	input  wire [3:0]  sel_i,
	input  wire [31:0] dat_i,
	output reg  [31:0] dat_o,
	output reg         ack_o,
	output reg         err_o,
	// internal events, one-cycle pulses from the same clock
	input  wire        rx_fifo_write_i,
	input  wire        tx_done_i,
	input  wire        tx_abort_i,
	input  wire        rx_desc_overrun_i,
	input  wire        rx_fifo_overflow_i,
	input  wire        frame_rx_ok_i,
	input  wire        frame_fcs_err_i,
	input  wire        frame_align_err_i,
	input  wire        buffer_count_increment_i,
	input  wire        buffer_count_decrement_i,
	// interrupt and status
	output wire        irq_o,
	output reg  [7:0]  rx_buffer_count_o
);

	reg  [6:0]  flags_reg;
	reg  [6:0]  flags_next;
	reg  [15:0] rxok_reg;
	reg  [15:0] rxok_next;
	wire [1:0]  ev_stat_reg;
	wire [1:0]  stat_clear;
	wire        pend_rise;
	wire        frame_counted;
	reg         rxok_wrap;
	wire [6:0]  flags_alias;
	wire [15:0] rxok_alias;
	reg  [1:0]  ev_mask_reg;
	reg  [1:0]  ev_mask_next;
	reg  [7:0]  rx_buffer_count_next;
	reg  [31:0] rd_data;
	reg         hit;

	wire        req = cyc_i & stb_i & ~ack_o & ~err_o;
	wire        wr  = req & we_i;
	wire        rd  = req & ~we_i;
	wire [5:0]  base = {adr_i[5:4], 4'h0};
	wire [1:0]  alias_sel = adr_i[3:2];
	wire        is_irq  = base == `IRQ_REQ_BASE;
	wire        is_rxok = base == `RXOK_STATS_BASE;
	wire        is_stat = adr_i == `IRQ_STAT_BASE;
	wire        is_mask = adr_i == `IRQ_MASK_BASE;
	wire        is_bcnt = adr_i == `RX_BUFFER_COUNT_BASE;

	// byte-enabled write data, unselected lanes act as zero
	wire [31:0] wmask = {{8{sel_i[3]}}, {8{sel_i[2]}}, {8{sel_i[1]}}, {8{sel_i[0]}}};
	wire [31:0] wdat  = dat_i & wmask;

	// value the flags and the frame counter would take from this write, one alias unit each
	alias_apply #(.W(7)) u_flags_alias (
		.cur_i   (flags_reg),
		.val_i   (wdat[6:0]),
		.lanes_i (wmask[6:0]),
		.kind_i  (alias_sel),
		.res_o   (flags_alias)
	);

	alias_apply #(.W(16)) u_rxok_alias (
		.cur_i   (rxok_reg),
		.val_i   (wdat[15:0]),
		.lanes_i (wmask[15:0]),
		.kind_i  (alias_sel),
		.res_o   (rxok_alias)
	);

	// a frame with any receive error is never counted
	assign frame_counted = frame_rx_ok_i & ~frame_fcs_err_i & ~frame_align_err_i;

	// write-one-to-clear strobes of the event status register
	assign stat_clear = {2{wr & is_stat}} & wdat[1:0];
	assign pend_rise  = flags_next[`FLAG_PEND] & ~flags_reg[`FLAG_PEND];

	// address decode and read mux
	always @* begin
		hit = 1'b1;
		rd_data = `ZERO32;
		if (is_irq) begin
			rd_data[6:0] = flags_reg;
			rd_data[`FLAG_UNUSED] = 1'b0;
		end else if (is_rxok) begin
			rd_data[15:0] = rxok_reg;
		end else if (is_stat) begin
			rd_data[1:0] = ev_stat_reg;
		end else if (is_mask) begin
			rd_data[1:0] = ev_mask_reg;
		end else if (is_bcnt) begin
			rd_data[7:0] = rx_buffer_count_o;
		end else begin
			hit = 1'b0;
		end
	end

	// buffer count: hardware increments, hardware decrement lowers it, not below zero
	always @* begin
		rx_buffer_count_next = rx_buffer_count_o;
		if (buffer_count_increment_i && !buffer_count_decrement_i)
			rx_buffer_count_next = rx_buffer_count_o + `BUF_STEP;
		else if (buffer_count_decrement_i && !buffer_count_increment_i &&
			rx_buffer_count_o != `RX_BUFFER_COUNT_RESET)
			rx_buffer_count_next = rx_buffer_count_o - `BUF_STEP;
		// limitation: the count wraps past all ones, the buffer manager must not overfill
	end

	// interrupt request flags
	always @* begin
		flags_next = flags_reg;
		// software write through any alias, pending and unused bits excluded
		if (wr && is_irq)
			flags_next = (flags_alias & `FLAG_SW_MASK) | (flags_reg & ~`FLAG_SW_MASK);
		// hardware sets win over a same-cycle clear
		if (rx_fifo_write_i)
			flags_next[`FLAG_ACT] = 1'b1;
		if (tx_done_i)
			flags_next[`FLAG_DONE] = 1'b1;
		if (tx_abort_i)
			flags_next[`FLAG_ABORT] = 1'b1;
		if (rx_desc_overrun_i)
			flags_next[`FLAG_BUFNA] = 1'b1;
		if (rx_fifo_overflow_i)
			flags_next[`FLAG_OVFLW] = 1'b1;
		// pending follows the count only, writes never touch it
		flags_next[`FLAG_PEND] = rx_buffer_count_next != `RX_BUFFER_COUNT_RESET;
		flags_next[`FLAG_UNUSED] = 1'b0;
	end

	// frames received ok counter
	always @* begin
		rxok_next = rxok_reg;
		rxok_wrap = 1'b0;
		if (wr && is_rxok)
			rxok_next = rxok_alias;
		// a read of the direct alias clears, unless both low byte enables are off
		if (rd && is_rxok && alias_sel == `ALIAS_DIRECT && (sel_i[0] | sel_i[1]))
			rxok_next = `RXOK_RESET;
		// a frame arriving with the read is counted after the clear, not lost
		if (frame_counted) begin
			rxok_next = rxok_next + `RXOK_STEP;
			rxok_wrap = rxok_next == `RXOK_RESET;
		end
	end

	// event status: a hardware set beats a same-cycle write-one clear
	sticky_event u_pend_rise (
		.clk_i   (clk_i),
		.rst_i   (rst_i),
		.set_i   (pend_rise),
		.clear_i (stat_clear[`EV_PEND]),
		.flag_o  (ev_stat_reg[`EV_PEND])
	);

	sticky_event u_rxok_wrap (
		.clk_i   (clk_i),
		.rst_i   (rst_i),
		.set_i   (rxok_wrap),
		.clear_i (stat_clear[`EV_RXOK_WRAP]),
		.flag_o  (ev_stat_reg[`EV_RXOK_WRAP])
	);

	always @* begin
		ev_mask_next = ev_mask_reg;
		if (wr && is_mask)
			ev_mask_next = (ev_mask_reg & ~wmask[1:0]) | wdat[1:0];
	end

	assign irq_o = |(ev_stat_reg & ev_mask_reg);

	// interrupt request flags
	always @(posedge clk_i) begin
		if (rst_i) begin
			flags_reg <= `FLAGS_RESET;
		end else begin
			flags_reg <= flags_next;
		end
	end

	// frames received ok counter
	always @(posedge clk_i) begin
		if (rst_i) begin
			rxok_reg <= `RXOK_RESET;
		end else begin
			rxok_reg <= rxok_next;
		end
	end

	// receive buffer count
	always @(posedge clk_i) begin
		if (rst_i) begin
			rx_buffer_count_o <= `RX_BUFFER_COUNT_RESET;
		end else begin
			rx_buffer_count_o <= rx_buffer_count_next;
		end
	end

	// event mask
	always @(posedge clk_i) begin
		if (rst_i) begin
			ev_mask_reg <= `EV_RESET;
		end else begin
			ev_mask_reg <= ev_mask_next;
		end
	end

	// bus answer, one wait-free cycle per access; data is zero outside a read answer
	// so a master that samples late sees nothing stale
	always @(posedge clk_i) begin
		if (rst_i) begin
			ack_o <= 1'b0;
			err_o <= 1'b0;
			dat_o <= `ZERO32;
		end else begin
			ack_o <= req & hit;
			err_o <= req & ~hit;
			dat_o <= (rd & hit) ? rd_data : `ZERO32;
		end
	end

endmodule

// direct, clear, set and invert write of one register
module alias_apply #(
	parameter W = 16
) (
	// current value and write
	input  wire [W-1:0] cur_i,
	input  wire [W-1:0] val_i,
	input  wire [W-1:0] lanes_i,
	input  wire [1:0]   kind_i,
	// value after the write
	output reg  [W-1:0] res_o
);

	// aliases act on the bits written as one, direct writes honour the lanes
	always @* begin
		case (kind_i)
			`ALIAS_DIRECT: res_o = (cur_i & ~lanes_i) | (val_i & lanes_i);
			`ALIAS_CLEAR:  res_o = cur_i & ~val_i;
			`ALIAS_SET:    res_o = cur_i | val_i;
			`ALIAS_INVERT: res_o = cur_i ^ val_i;
			default:       res_o = cur_i;
		endcase
	end

endmodule

// sticky event bit, set by hardware and cleared by writing a one
module sticky_event (
	// clock and reset
	input  wire clk_i,
	input  wire rst_i,
	// set and clear strobes
	input  wire set_i,
	input  wire clear_i,
	// flag
	output reg  flag_o
);

	always @(posedge clk_i) begin
		if (rst_i) begin
			flag_o <= `EV_BIT_RESET;
		end else begin
			// set wins so that an event racing the clear is not lost
			flag_o <= set_i | (flag_o & ~clear_i);
		end
	end

endmodule

/* tb/eth_irq_status_asserts.sv */
// concurrent checks on the ports of the ethernet status block
`timescale 1ns/1ps
module irq_chk (
	input wire       clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, err_o,
	input wire       buffer_count_increment_i, buffer_count_decrement_i,
	input wire [5:0] adr_i,
	input wire [31:0] dat_o,
	input wire [7:0] rx_buffer_count_o
);
	wire       inc = buffer_count_increment_i;
	wire       dec = buffer_count_decrement_i;
	wire [7:0] cnt = rx_buffer_count_o;
	wire       rd  = ack_o && !we_i;
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	ack_pulse_a: assert property (ack_o |=> !ack_o) else $error("ack too long");
	ack_time_a: assert property (cyc_i && stb_i && !ack_o && !err_o |=> ack_o || err_o)
		else $error("no answer");
	err_alone_a: assert property (err_o |-> !ack_o ##1 !err_o) else $error("bad err");
	dat_idle_a: assert property (!ack_o |-> dat_o == 32'h0) else $error("dat not idle");
	cnt_up_a: assert property (inc && !dec && cnt != 8'hff |=> cnt == $past(cnt) + 8'h1)
		else $error("count up");
	cnt_down_a: assert property (dec && !inc && cnt != 8'h0 |=> cnt == $past(cnt) - 8'h1)
		else $error("count down");
	cnt_hold_a: assert property (inc == dec |=> $stable(cnt)) else $error("count moved");
	upper_zero_a: assert property (rd && adr_i[5:4] == 2'h1 |-> dat_o[31:16] == 16'h0)
		else $error("upper bits");
	unused_zero_a: assert property (rd && adr_i[5:4] == 2'h0 |-> !dat_o[4])
		else $error("bit four");
	cover property (ack_o && we_i);
	cover property (err_o);
	cover property (dec && cnt != 8'h0);
endmodule
bind eth_irq_status irq_chk u_chk (.*);

/* tb/tb_eth_irq_status.sv */
// self-checking testbench of the ethernet status block
`timescale 1ns/1ps
module tb_eth_irq_status;
	reg         clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0, er;
	reg  [5:0]  adr_i = 0;
	reg  [3:0]  sel_i = 0;
	reg  [31:0] dat_i = 0, rd;
	reg  [9:0]  ev = 0;
	reg  [3:0]  rows [0:4] = '{4'h5, 4'h3, 4'h2, 4'h1, 4'h0};
	wire [31:0] dat_o;
	wire        ack_o, err_o, irq_o;
	wire [7:0]  rx_buffer_count_o;
	integer     mismatches = 0, compares = 0, cyc_n = 0, i;
	// ev bit 4 drives the alignment error so bits 0..5 line up with the flags
	eth_irq_status DUT (.*, .rx_fifo_write_i(ev[5]), .tx_done_i(ev[3]), .tx_abort_i(ev[2]),
		.rx_desc_overrun_i(ev[1]), .rx_fifo_overflow_i(ev[0]), .frame_rx_ok_i(ev[8]),
		.frame_fcs_err_i(ev[9]), .frame_align_err_i(ev[4]),
		.buffer_count_increment_i(ev[6]), .buffer_count_decrement_i(ev[7]));
	initial forever #2.5 clk_i = ~clk_i;
	task give_verdict;
		$display("compares %0d mismatches %0d", compares, mismatches);
		if (mismatches == 0 && compares > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	always @(posedge clk_i) if (++cyc_n > 1000) begin
		mismatches++;
		give_verdict;
	end
	task chk(input [31:0] g, e);
		compares++;
		if (g !== e) begin
			mismatches++;
			$display("[ERR] %0t got %h exp %h", $time, g, e);
		end
	endtask
	task wb(input w, input [5:0] a, input [3:0] s, input [31:0] d);
		@(posedge clk_i);
		{cyc_i, stb_i, we_i, adr_i, sel_i, dat_i} <= {2'b11, w, a, s, d};
		do @(posedge clk_i); while (ack_o !== 1'b1 && err_o !== 1'b1);
		rd = dat_o;
		er = err_o;
		{cyc_i, stb_i} <= 2'b00;
	endtask
	task rdc(input [5:0] a, input [31:0] e);
		wb(0, a, 4'hf, 0);
		chk(rd, e);
	endtask
	task pulse(input [9:0] v);
		@(posedge clk_i) ev <= v;
		@(posedge clk_i) ev <= 0;
	endtask
	initial begin
		repeat (2) @(posedge clk_i);
		rst_i <= 0;
		rdc(6'h00, 0);
		rdc(6'h10, 0);
		for (i = 0; i < 5; i++) begin
			pulse(10'h1 << rows[i]);
			rdc(6'h00, 32'h1 << rows[i]);
			wb(1, 6'h04, 4'hf, 32'h1 << rows[i]);
			rdc(6'h00, 0);
		end
		$display("flag rows done");
		pulse(10'h040);
		rdc(6'h00, 32'h40);
		wb(1, 6'h00, 4'hf, 0);
		wb(1, 6'h04, 4'hf, 32'h40);
		rdc(6'h00, 32'h40);
		rdc(6'h28, 1);
		pulse(10'h080);
		rdc(6'h00, 0);
		wb(1, 6'h0c, 4'hf, 32'h30);
		rdc(6'h00, 32'h20);
		$display("pending and alias done");
		pulse(10'h100);
		pulse(10'h300);
		pulse(10'h110);
		rdc(6'h10, 1);
		rdc(6'h10, 0);
		pulse(10'h100);
		wb(0, 6'h10, 4'hc, 0);
		rdc(6'h10, 1);
		wb(1, 6'h18, 4'hf, 32'hffffffff);
		rdc(6'h10, 32'hffff);
		wb(1, 6'h18, 4'hf, 32'hffff);
		pulse(10'h100);
		rdc(6'h10, 0);
		chk(irq_o, 0);
		wb(1, 6'h24, 4'hf, 2);
		chk(irq_o, 1);
		rdc(6'h20, 3);
		rdc(6'h24, 2);
		wb(1, 6'h20, 4'hf, 3);
		chk(irq_o, 0);
		wb(1, 6'h3c, 4'hf, 0);
		chk(er, 1);
		$display("counter irq err done");
		rst_i <= 1;
		repeat (2) @(posedge clk_i);
		rst_i <= 0;
		rdc(6'h00, 0);
		rdc(6'h28, 0);
		$display("reset done");
		give_verdict;
	end
endmodule
